// file: logic/event_input_filter.sv
`timescale 1ns/1ps
`default_nettype none
module event_input_filter
  import oneshot_pwm_event_timer_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  event_input_if.filt ev
);
  logic syncA_reg, syncB_reg, level_reg, prevLevel_reg, prevFast_reg;
  logic [FILTER_DEPTH-1:0] samples_reg;
  logic [FILTER_DEPTH-1:0] samples_next;
  logic level_next;

  // Level update: four agreeing samples, or straight through when off
  always_comb begin
    samples_next = {samples_reg[FILTER_DEPTH-2:0], syncB_reg};
    level_next = level_reg;
    if (!ev.filterOn) begin
      level_next = syncB_reg;
    end else if (&samples_reg) begin
      level_next = 1'b1;
    end else if (~|samples_reg) begin
      level_next = 1'b0;
    end
  end

  // Two-stage synchroniser, then sample history
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_reg <= 1'b0;
      syncB_reg <= 1'b0;
      samples_reg <= '0;
      level_reg <= 1'b0;
      prevLevel_reg <= 1'b0;
      prevFast_reg <= 1'b0;
    end else begin
      syncA_reg <= ev.rawIn;
      syncB_reg <= syncA_reg;
      samples_reg <= samples_next;
      level_reg <= level_next;
      prevLevel_reg <= level_reg;
      prevFast_reg <= syncB_reg;
    end
  end

  // Edge pulses; fast pair skips the filter for quicker reaction
  assign ev.level = level_reg;
  assign ev.rise = level_reg & ~prevLevel_reg;
  assign ev.fall = ~level_reg & prevLevel_reg;
  assign ev.fastRise = syncB_reg & ~prevFast_reg;
  assign ev.fastFall = ~syncB_reg & prevFast_reg;

  a_filter_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    ev.filterOn && !(&samples_reg) && (|samples_reg)
    |=> $stable(level_reg))
    else $error("filtered level moved on disagreeing samples");
endmodule : event_input_filter
`default_nettype wire

// file: logic/event_input_if.sv
`timescale 1ns/1ps
`default_nettype none
interface event_input_if;
  logic rawIn;
  logic filterOn;
  logic level;
  logic rise;
  logic fall;
  logic fastRise;
  logic fastFall;
  modport filt (input rawIn, input filterOn, output level, output rise,
    output fall, output fastRise, output fastFall);
  modport user (output rawIn, output filterOn, input level, input rise,
    input fall, input fastRise, input fastFall);
endinterface : event_input_if
`default_nettype wire

// file: logic/oneshot_pwm_event_timer.sv
`timescale 1ns/1ps
`default_nettype none
module oneshot_pwm_event_timer
  import oneshot_pwm_event_timer_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic timerEnable,
  input wire logic [2:0] timerModeSelect,
  input wire logic [1:0] clockSourceSelect,
  input wire logic restartWithPartner,
  input wire logic waveformOutputEnable,
  input wire logic outputInitialLevel,
  input wire logic immediateTrigger,
  input wire logic triggerInputEnable,
  input wire logic eventEdge,
  input wire logic noiseFilterEnable,
  input wire logic [15:0] compareValue,
  input wire logic counterLoad,
  input wire logic [15:0] counterLoadValue,
  input wire logic partnerTimerTick,
  input wire logic partnerRestart,
  input wire logic triggerEventIn,
  input wire logic countEventIn,
  input wire logic eventHitFlagClear,
  output logic waveformOut,
  output logic [15:0] counterValue,
  output logic counterRunning,
  output logic eventHitFlag,
  output logic eventOut
);
  event_input_if trigIf ();
  event_input_if countIf ();

  // Trigger path may be filtered; count path never is
  assign trigIf.rawIn = triggerEventIn;
  assign trigIf.filterOn = noiseFilterEnable;
  assign countIf.rawIn = countEventIn;
  assign countIf.filterOn = 1'b0;

  event_input_filter trigFilter (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ev(trigIf.filt)
  );
  event_input_filter countFilter (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ev(countIf.filt)
  );

  shot_state_t state_reg, state_next;
  logic [15:0] count_reg, count_next;
  logic out_reg, out_next;
  logic flag_reg, flag_next;
  logic evOut_reg, evOut_next;
  logic div_reg, div_next;
  logic enPrev_reg;
  logic tick, isSingle, isPwm, trig, hit, enRise;

  assign isSingle = timerModeSelect == MODE_SINGLE;
  assign isPwm = timerModeSelect == MODE_PWM8;
  assign enRise = timerEnable & ~enPrev_reg;

  // Count tick per clock source
  always_comb begin
    unique case (clockSourceSelect)
      CLK_DIV1: tick = 1'b1;
      CLK_DIV2: tick = div_reg;
      CLK_PARTNER: tick = partnerTimerTick;
      CLK_EVENT: tick = countIf.rise;
    endcase
  end

  // Qualified trigger edge; immediate mode takes the unfiltered edge
  always_comb begin
    if (!triggerInputEnable || !timerEnable) begin
      trig = 1'b0;
    end else if (immediateTrigger && isSingle) begin
      trig = eventEdge ? trigIf.fastFall : trigIf.fastRise;
    end else begin
      trig = eventEdge ? trigIf.fall : trigIf.rise;
    end
  end

  // Counter and single-shot sequencing
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    hit = 1'b0;
    div_next = timerEnable ? ~div_reg : 1'b0;
    if (!timerEnable) begin
      state_next = SHOT_IDLE;
    end else if (isSingle) begin
      unique case (state_reg)
        SHOT_IDLE: begin
          if (enRise && count_reg != COUNTER_TOP) begin
            state_next = SHOT_RUN;
          end else if (trig) begin
            state_next = SHOT_DELAY;
          end
        end
        SHOT_DELAY: begin
          state_next = SHOT_RUN;
          count_next = COUNTER_RESET;
        end
        SHOT_RUN: begin
          if (tick) begin
            if (count_reg == compareValue) begin
              state_next = SHOT_HOLD;
              hit = 1'b1;
            end else begin
              count_next = count_reg + COUNTER_STEP;
            end
          end
        end
        SHOT_HOLD: begin
          if (tick) begin
            state_next = SHOT_IDLE;
          end
        end
        default: state_next = SHOT_IDLE;
      endcase
    end else begin
      state_next = SHOT_IDLE;
      if (tick) begin
        if (isPwm && count_reg[7:0] >= compareValue[7:0]) begin
          count_next = COUNTER_RESET;
          hit = 1'b1;
        end else if (!isPwm && count_reg == compareValue) begin
          count_next = COUNTER_RESET;
          hit = 1'b1;
        end else begin
          count_next = count_reg + COUNTER_STEP;
        end
      end
    end
    if (timerEnable && restartWithPartner && partnerRestart &&
        !(isSingle && state_reg != SHOT_RUN)) begin
      count_next = COUNTER_RESET;
    end
    if (counterLoad) begin
      count_next = counterLoadValue;
    end
  end

  // Waveform level from the next state so the pin matches its cause
  always_comb begin
    if (!waveformOutputEnable || !timerEnable) begin
      out_next = 1'b0;
    end else if (isSingle) begin
      out_next = (state_next == SHOT_RUN) ||
        (immediateTrigger && state_next == SHOT_DELAY);
    end else if (isPwm) begin
      out_next = count_next[7:0] < compareValue[15:8];
    end else begin
      out_next = outputInitialLevel;
    end
  end

  // Hit flag: a new hit beats a same-cycle clear
  always_comb begin
    flag_next = hit | (flag_reg & ~eventHitFlagClear);
    evOut_next = hit;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SHOT_IDLE;
      count_reg <= COUNTER_RESET;
      out_reg <= 1'b0;
      flag_reg <= 1'b0;
      evOut_reg <= 1'b0;
      div_reg <= 1'b0;
      enPrev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      out_reg <= out_next;
      flag_reg <= flag_next;
      evOut_reg <= evOut_next;
      div_reg <= div_next;
      enPrev_reg <= timerEnable;
    end
  end

  // Status registered from the next state
  logic running_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      running_reg <= 1'b0;
    end else begin
      running_reg <= timerEnable &&
        (isSingle ? state_next == SHOT_RUN : 1'b1);
    end
  end

  assign waveformOut = out_reg;
  assign counterValue = count_reg;
  assign counterRunning = running_reg;
  assign eventHitFlag = flag_reg;
  assign eventOut = evOut_reg;

  // Checks on the sequencing
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_idle_out_low: assert property (
    isSingle && $stable(timerModeSelect) && state_reg == SHOT_IDLE
    |-> !waveformOut)
    else $error("single-shot output high while stopped");
  a_sync_rise_two: assert property (
    state_reg == SHOT_IDLE && trig && isSingle && !immediateTrigger &&
    !enRise && !counterLoad && waveformOutputEnable
    ##1 (waveformOutputEnable && timerEnable && isSingle)
    |-> !waveformOut ##1 waveformOut)
    else $error("output did not rise two clocks after trigger");
  a_imm_out_now: assert property (
    state_reg == SHOT_IDLE && trig && isSingle && immediateTrigger &&
    !enRise && waveformOutputEnable |=> waveformOut)
    else $error("immediate trigger did not set output");
  a_imm_count_later: assert property (
    state_reg == SHOT_IDLE && trig && isSingle && immediateTrigger &&
    !enRise ##1 (timerEnable && isSingle)
    |-> !counterRunning ##1 counterRunning)
    else $error("count start not two clocks after immediate trigger");
  a_stop_at_cmp: assert property (
    isSingle && state_reg == SHOT_RUN && tick && timerEnable &&
    count_reg == compareValue |=> !counterRunning && eventHitFlag)
    else $error("single-shot did not stop at compare");
  a_hold_ignores: assert property (
    state_reg == SHOT_HOLD && !tick && timerEnable && isSingle
    |=> state_reg == SHOT_HOLD)
    else $error("trigger accepted during hold");
  a_pwm_wrap: assert property (
    isPwm && timerEnable && tick && !counterLoad &&
    !(restartWithPartner && partnerRestart) &&
    count_reg[7:0] == compareValue[7:0] |=> counterValue == 16'h0000)
    else $error("PWM counter did not wrap at low byte");
  a_pwm_level: assert property (
    isPwm && timerEnable && waveformOutputEnable
    |=> waveformOut == (counterValue[7:0] < $past(compareValue[15:8])))
    else $error("PWM level disagrees with high byte");
  a_init_level: assert property (
    !isSingle && !isPwm && timerEnable && waveformOutputEnable
    |=> waveformOut == $past(outputInitialLevel))
    else $error("output does not follow initial level");
  a_no_drive_off: assert property (
    !waveformOutputEnable |=> !waveformOut)
    else $error("waveform driven with output disabled");
  a_event_pulse: assert property (
    eventOut |-> eventHitFlag ##1 (eventOut -> $past(hit)))
    else $error("event pulse without hit flag");
  a_partner_restart: assert property (
    timerEnable && !isSingle && restartWithPartner && partnerRestart &&
    !counterLoad |=> counterValue == 16'h0000)
    else $error("counter ignored partner restart");

  c_single_shot: cover property (state_reg == SHOT_RUN ##1
    state_reg == SHOT_HOLD);
  c_pwm_wrap: cover property (isPwm && hit);
  c_imm_trigger: cover property (trig && immediateTrigger && isSingle);
endmodule : oneshot_pwm_event_timer
`default_nettype wire

// file: logic/oneshot_pwm_event_timer_pkg.sv
package oneshot_pwm_event_timer_pkg;
  localparam logic [2:0] MODE_SINGLE = 3'h6;
  localparam logic [2:0] MODE_PWM8 = 3'h7;
  localparam logic [1:0] CLK_DIV1 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_PARTNER = 2'h2;
  localparam logic [1:0] CLK_EVENT = 2'h3;
  localparam int FILTER_DEPTH = 4;
  localparam logic [15:0] COUNTER_TOP = 16'hFFFF;
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [15:0] COUNTER_STEP = 16'h0001;
  typedef enum logic [3:0] {
    SHOT_IDLE = 4'h1,
    SHOT_DELAY = 4'h2,
    SHOT_RUN = 4'h4,
    SHOT_HOLD = 4'h8
  } shot_state_t;
endpackage : oneshot_pwm_event_timer_pkg

// file: tb/oneshot_pwm_event_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module oneshot_pwm_event_timer_tb;
  import oneshot_pwm_event_timer_pkg::*;
  typedef struct {int w; int p;} pulse_t;
  logic core_clk, rst_n, timerEnable, immediateTrigger, noiseFilterEnable;
  logic waveformOutputEnable, outputInitialLevel, counterLoad, fire, tickOn;
  logic eventHitFlagClear, triggerEventIn, countEventIn, partnerTimerTick;
  logic partnerRestart, waveformOut, counterRunning, eventHitFlag, eventOut;
  logic [2:0] timerModeSelect;
  logic [1:0] clockSourceSelect;
  logic [15:0] compareValue, counterLoadValue, counterValue;
  pulse_t expQ[$];
  int n_mismatch = 0, tests_run = 0, seed = 705, sinceRise = 0, width = 0;
  int lastPeriod = 0, evCount = 0;
  bit wasHigh = 0;
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  timer_partner_model u_partner (.core_clk(core_clk), .rst_n(rst_n),
    .fire(fire), .holdLen(4'h6), .tickOn(tickOn),
    .triggerEventIn(triggerEventIn), .partnerTimerTick(partnerTimerTick),
    .partnerRestart(partnerRestart), .countEventIn(countEventIn));
  oneshot_pwm_event_timer u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .timerEnable(timerEnable), .timerModeSelect(timerModeSelect),
    .clockSourceSelect(clockSourceSelect), .restartWithPartner(1'b0),
    .waveformOutputEnable(waveformOutputEnable),
    .outputInitialLevel(outputInitialLevel),
    .immediateTrigger(immediateTrigger), .triggerInputEnable(1'b1),
    .eventEdge(1'b0), .noiseFilterEnable(noiseFilterEnable),
    .compareValue(compareValue), .counterLoad(counterLoad),
    .counterLoadValue(counterLoadValue),
    .partnerTimerTick(partnerTimerTick), .partnerRestart(partnerRestart),
    .triggerEventIn(triggerEventIn), .countEventIn(countEventIn),
    .eventHitFlagClear(eventHitFlagClear), .waveformOut(waveformOut),
    .counterValue(counterValue), .counterRunning(counterRunning),
    .eventHitFlag(eventHitFlag), .eventOut(eventOut));
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk
  task automatic results();
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse
  // Bounded wait; a hang is counted and ends the run
  task automatic waitFor(bit rise, output int n);
    n = 0;
    while (rise ? (waveformOut !== 1'b1) : (expQ.size() != 0)) begin
      @(negedge core_clk);
      n++;
      if (n > 400) begin
        n_mismatch++;
        results();
      end
    end
  endtask : waitFor
  // Monitor: each pulse that finishes while a note is queued is judged against the oldest note
  always @(negedge core_clk) begin
    sinceRise++;
    if (eventOut === 1'b1) evCount++;
    if (waveformOut === 1'b1) begin
      if (!wasHigh) begin
        lastPeriod = sinceRise;
        sinceRise = 0;
        width = 0;
      end
      width++;
    end else if (wasHigh && expQ.size() > 0) begin
      chk("width", 16'(expQ[0].w), 16'(width));
      if (expQ[0].p != 0) chk("period", 16'(expQ[0].p), 16'(lastPeriod));
      void'(expQ.pop_front());
    end
    wasHigh = (waveformOut === 1'b1);
  end
  initial begin
    int r, n, c, ev0;
    int lat[3];
    logic [7:0] lo, hi;
    {timerEnable, immediateTrigger, noiseFilterEnable, outputInitialLevel} = 4'h0;
    {counterLoad, fire, tickOn, eventHitFlagClear} = 4'h0;
    waveformOutputEnable = 1'b1;
    timerModeSelect = MODE_PWM8;
    clockSourceSelect = CLK_DIV1;
    compareValue = 16'h0000;
    counterLoadValue = COUNTER_RESET;
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    chk("reset", 16'h0, {12'h0, waveformOut, counterRunning, eventHitFlag, eventOut});
    // Every clock source, random duty and period; scale is clocks per step
    for (int s = 0; s < 4; s++) begin
      r = $random(seed);
      lo = 8'h04 + 8'(r[3:0]);
      hi = 8'h01 + 8'(r[11:4] % (lo - 8'h01));
      clockSourceSelect = 2'(s);
      tickOn = 1'b1;
      compareValue = {hi, lo};
      pulse(counterLoad);
      timerEnable = 1'b1;
      c = (s == 0) ? 1 : 2;
      tick((lo + 1) * c * 2 + 8);
      repeat (3) expQ.push_back('{hi * c, (lo + 1) * c});
      waitFor(1'b0, n);
      timerEnable = 1'b0;
      tick(2);
    end
    // No waveform while output is disabled, initial level in other modes
    waveformOutputEnable = 1'b0;
    clockSourceSelect = CLK_DIV1;
    timerEnable = 1'b1;
    n = 0;
    repeat (40) begin
      tick(1);
      if (waveformOut !== 1'b0) n++;
    end
    chk("disabled", 16'h0, 16'(n));
    timerEnable = 1'b0;
    waveformOutputEnable = 1'b1;
    outputInitialLevel = 1'b1;
    timerModeSelect = 3'h0;
    timerEnable = 1'b1;
    tick(3);
    chk("initLevel", 16'h1, {15'h0, waveformOut});
    timerEnable = 1'b0;
    timerModeSelect = MODE_SINGLE;
    r = $random(seed);
    compareValue = 16'h0008 + 16'(r[2:0]);
    counterLoadValue = COUNTER_TOP;
    pulse(counterLoad);
    timerEnable = 1'b1;
    pulse(eventHitFlagClear);
    tick(3);
    chk("idle", 16'h0, {14'h0, waveformOut, counterRunning});
    // Sync, immediate, then filtered trigger, each retriggered mid-pulse
    for (int i = 0; i < 3; i++) begin
      immediateTrigger = (i == 1);
      noiseFilterEnable = (i == 2);
      ev0 = evCount;
      // Immediate mode also drives high through the start-up delay cycle
      expQ.push_back('{compareValue + 1 + (i == 1), 0});
      pulse(fire);
      waitFor(1'b1, lat[i]);
      if (i == 1) begin
        chk("runLate", 16'h0, {15'h0, counterRunning});
        @(negedge core_clk);
        chk("runOn", 16'h1, {15'h0, counterRunning});
      end
      tick(3);
      pulse(fire);
      waitFor(1'b0, n);
      tick(3);
      chk("flag", 16'h1, {15'h0, eventHitFlag});
      chk("evOut", 16'h1, 16'(evCount - ev0));
      pulse(eventHitFlagClear);
      tick(2);
    end
    chk("immLead", 16'(lat[0] - 2), 16'(lat[1]));
    chk("filtLag", 16'(lat[0] + 4), 16'(lat[2]));
    // Enabling without loading the top value starts a count at once
    timerEnable = 1'b0;
    counterLoadValue = COUNTER_RESET;
    pulse(counterLoad);
    timerEnable = 1'b1;
    tick(4);
    chk("selfStart", 16'h1, {15'h0, counterRunning});
    tick(20);
    results();
  end
endmodule : oneshot_pwm_event_timer_tb
`default_nettype wire

// file: tb/timer_partner_model.sv
`timescale 1ns/1ps
`default_nettype none
module timer_partner_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic fire,
  input wire logic [3:0] holdLen,
  input wire logic tickOn,
  output logic triggerEventIn,
  output logic partnerTimerTick,
  output logic partnerRestart,
  output logic countEventIn
);
  logic [3:0] holdCnt;
  logic tickPh;
  // Event held holdLen clocks, never shorter than one clock
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      holdCnt <= 4'h0;
      tickPh <= 1'b0;
    end else begin
      if (fire) begin
        holdCnt <= (holdLen == 4'h0) ? 4'h1 : holdLen;
      end else if (holdCnt != 4'h0) begin
        holdCnt <= holdCnt - 4'h1;
      end
      tickPh <= tickOn & ~tickPh;
    end
  end
  // Idle level of the routed event is low
  assign triggerEventIn = (holdCnt != 4'h0);
  // One tick every second clock, shared by partner and event clocks
  assign partnerTimerTick = tickPh;
  assign countEventIn = tickPh;
  // No restarts: restart following stays unexercised
  assign partnerRestart = 1'b0;
endmodule : timer_partner_model
`default_nettype wire
